// File: inc/idp_defs.svh
// offsets, field positions, reset values and interrupt channels of the isolated dio port
// assumes byte addresses relative to the card's i/o base, 32-bit data words
`ifndef IDP_DEFS_SVH
`define IDP_DEFS_SVH

// card i/o register offsets
`define IDP_OFF_PORT0       8'h00
`define IDP_OFF_PORT1       8'h04
`define IDP_OFF_CLR_IN      8'h08
`define IDP_OFF_CLR_CMB     8'h40
`define IDP_OFF_LED         8'h50

// bus configuration header offsets
`define IDP_CFG_LCR_BAR     8'h14
`define IDP_CFG_IO_BAR      8'h18

// i/o window: base compare from this bit upward
`define IDP_IO_WIN_LSB      7
// i/o space indicator bit of a base address entry
`define IDP_BAR_IO_BIT      0

// full-word byte enables
`define IDP_BE_FULL         4'hF

// reset values
`define IDP_OUT_RST         32'h0000_0000
`define IDP_BAR_RST         32'h0000_0000
`define IDP_ZERO_WORD       32'h0000_0000

// interrupt source channels
`define IDP_IRQ_CH_A        0
`define IDP_IRQ_CH_B        1

`endif

// File: inc/idp_pkg.sv
// types of the isolated dio port: variants, register selects, bus carriers
// assumes idp_defs.svh supplies every numeric constant
package idp_pkg;

    typedef enum logic [1:0] {
        IDP_VAR_COMBINED = 2'b00,
        IDP_VAR_IN_ONLY  = 2'b01,
        IDP_VAR_OUT_ONLY = 2'b11
    } idp_variant_t;

    typedef enum logic [2:0] {
        IDP_REG_NONE  = 3'b000,
        IDP_REG_PORT0 = 3'b001,
        IDP_REG_PORT1 = 3'b011,
        IDP_REG_CLR   = 3'b010,
        IDP_REG_LED   = 3'b110
    } idp_reg_t;

    typedef struct packed {
        logic        wr;
        logic [3:0]  be;
        logic [31:0] addr;
        logic [31:0] wdata;
    } idp_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } idp_rsp_t;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } idp_cfg_req_t;

endpackage

// File: hw/idp_in_sync.sv
// three-stage pin synchroniser; a change counts once stages two and three agree
// assumes pins are asynchronous to clk_sys_i
`timescale 1ns/100ps
module idp_in_sync
    import idp_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         reset_n_i,
    // pins in, settled level out
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_d;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // take stage three only where it agrees with stage two
    always_comb begin
        level_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level_o);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            level_o <= '0;
        end else begin
            level_o <= level_d;
        end
    end

endmodule // idp_in_sync

// File: hw/idp_port.sv
// register port of the isolated dio card behind the bridge's local bus
// assumes one 32-bit target access per request pulse, full i/o address on the bus
`timescale 1ns/100ps
`include "idp_defs.svh"

// Behaviour
// - only full 32-bit accesses act; narrower accesses are acknowledged and ignored
// - the port is a target only; it answers requests and never starts any
// - header offset 14h holds the bridge local configuration base address
// - header offset 18h holds the card's own i/o base address
// - combined variant: write 0x00 sets outputs, read 0x00 gives inputs
// - 32 input channels on combined variant, 64 on input-only variant
// - input bit n is channel n, byte n/8 bit n mod 8; read-only
// - input-only variant: channels 0-31 at 0x00, 32-63 at 0x04
// - combined variant drives 32 output channels from the word at 0x00
// - output bit n drives channel n, byte n/8 bit n mod 8; write-only
// - output-only variant: channels 0-31 at 0x00, 32-63 at 0x04; reads undefined
// - combined variant: a write to 0x40 clears pending interrupts
// - input-only variant: a write to 0x08 clears pending interrupts
// - rear input-only and output-only variants: write 0x50 sets led control, read gives slot number
// - interrupts come from input channels 0 and 1, each with own enable
module idp_port
    import idp_pkg::*;
#(
    parameter idp_variant_t VARIANT = IDP_VAR_COMBINED,
    parameter bit           REAR_IO = 1'b0,
    parameter int           LED_W   = 4,
    parameter int           SLOT_W  = 5
) (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_n_i,
    // local bus target
    input  wire logic              lb_valid_i,
    input  wire idp_req_t          lb_req_i,
    output idp_rsp_t               lb_rsp_o,
    // configuration header access
    input  wire logic              cfg_valid_i,
    input  wire idp_cfg_req_t      cfg_req_i,
    output logic        [31:0]     cfg_rdata_o,
    // isolated channels
    input  wire logic   [63:0]     iso_in_i,
    output logic        [63:0]     iso_out_o,
    // interrupt enables and request
    input  wire logic   [1:0]      int_en_i,
    output logic        [1:0]      int_pend_o,
    output logic                   irq_o,
    // rear panel led and backplane slot
    input  wire logic   [SLOT_W-1:0] slot_i,
    output logic        [LED_W-1:0]  led_o
);

    localparam bit HAS_IN  = (VARIANT != IDP_VAR_OUT_ONLY);
    localparam bit HAS_OUT = (VARIANT != IDP_VAR_IN_ONLY);
    localparam bit WIDE    = (VARIANT != IDP_VAR_COMBINED);

    // register decode shared by reads and writes
    function automatic idp_reg_t idp_decode(input logic [7:0] off);
        idp_reg_t r;
        r = IDP_REG_NONE;
        case (off)
            `IDP_OFF_PORT0: begin
                r = IDP_REG_PORT0;
            end
            `IDP_OFF_PORT1: begin
                if (WIDE) begin
                    r = IDP_REG_PORT1;
                end
            end
            `IDP_OFF_CLR_IN: begin
                if (VARIANT == IDP_VAR_IN_ONLY) begin
                    r = IDP_REG_CLR;
                end
            end
            `IDP_OFF_CLR_CMB: begin
                if (VARIANT == IDP_VAR_COMBINED) begin
                    r = IDP_REG_CLR;
                end
            end
            `IDP_OFF_LED: begin
                if (REAR_IO && WIDE) begin
                    r = IDP_REG_LED;
                end
            end
            default: begin
                r = IDP_REG_NONE;
            end
        endcase
        return r;
    endfunction

    // settled pin levels
    logic [63:0]        in_lvl;
    logic [SLOT_W-1:0]  slot_lvl;

    idp_in_sync #(
        .W (64)
    ) u_in_sync (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .pin_i     (iso_in_i),
        .level_o   (in_lvl)
    );

    idp_in_sync #(
        .W (SLOT_W)
    ) u_slot_sync (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .pin_i     (slot_i),
        .level_o   (slot_lvl)
    );

    // configuration header base addresses
    logic [31:0] lcr_bar_q;
    logic [31:0] io_bar_q;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            lcr_bar_q <= `IDP_BAR_RST;
            io_bar_q  <= `IDP_BAR_RST;
        end else if (cfg_valid_i && cfg_req_i.wr) begin
            if (cfg_req_i.addr == `IDP_CFG_LCR_BAR) begin
                lcr_bar_q <= cfg_req_i.wdata;
            end
            if (cfg_req_i.addr == `IDP_CFG_IO_BAR) begin
                io_bar_q <= cfg_req_i.wdata;
            end
        end
    end

    // header read-back, i/o space flag forced set
    logic [31:0] cfg_rdata_d;

    always_comb begin
        cfg_rdata_d = `IDP_ZERO_WORD;
        if (cfg_req_i.addr == `IDP_CFG_LCR_BAR) begin
            cfg_rdata_d = lcr_bar_q;
            cfg_rdata_d[`IDP_BAR_IO_BIT] = 1'b1;
        end else if (cfg_req_i.addr == `IDP_CFG_IO_BAR) begin
            cfg_rdata_d = io_bar_q;
            cfg_rdata_d[`IDP_BAR_IO_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            cfg_rdata_o <= `IDP_ZERO_WORD;
        end else if (cfg_valid_i && !cfg_req_i.wr) begin
            cfg_rdata_o <= cfg_rdata_d;
        end
    end

    // local bus access qualification
    logic     hit;
    logic     full;
    idp_reg_t sel;
    logic     wr_act;
    logic     rd_act;

    always_comb begin
        hit = lb_req_i.addr[31:`IDP_IO_WIN_LSB] == io_bar_q[31:`IDP_IO_WIN_LSB];
        full = lb_req_i.be == `IDP_BE_FULL;
        sel = idp_decode({1'b0, lb_req_i.addr[`IDP_IO_WIN_LSB-1:0]});
        wr_act = lb_valid_i && hit && full && lb_req_i.wr;
        rd_act = lb_valid_i && hit && full && !lb_req_i.wr;
    end

    // output latches
    logic [31:0] out_lo_q;
    logic [31:0] out_hi_q;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            out_lo_q <= `IDP_OUT_RST;
            out_hi_q <= `IDP_OUT_RST;
        end else if (wr_act && HAS_OUT) begin
            if (sel == IDP_REG_PORT0) begin
                out_lo_q <= lb_req_i.wdata;
            end
            if (sel == IDP_REG_PORT1) begin
                out_hi_q <= lb_req_i.wdata;
            end
        end
    end

    // bit n of the word drives channel n
    always_comb begin
        iso_out_o = {(WIDE ? out_hi_q : `IDP_ZERO_WORD), out_lo_q};
        if (!HAS_OUT) begin
            iso_out_o = '0;
        end
    end

    // interrupt sources from input channels 0 and 1
    logic [1:0] src_prev_q;
    logic [1:0] src_now;
    logic [1:0] src_rise;
    logic       clr_hit;

    always_comb begin
        src_now  = {in_lvl[`IDP_IRQ_CH_B], in_lvl[`IDP_IRQ_CH_A]};
        src_rise = src_now & ~src_prev_q & int_en_i;
        clr_hit  = wr_act && (sel == IDP_REG_CLR);
        if (!HAS_IN) begin
            src_rise = 2'b00;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            src_prev_q <= 2'b00;
        end else begin
            src_prev_q <= src_now;
        end
    end

    // a new event in the clearing cycle stays pending
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            int_pend_o <= 2'b00;
        end else begin
            int_pend_o <= (clr_hit ? 2'b00 : int_pend_o) | src_rise;
        end
    end

    assign irq_o = |int_pend_o;

    // led control latch
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            led_o <= '0;
        end else if (wr_act && sel == IDP_REG_LED) begin
            led_o <= lb_req_i.wdata[LED_W-1:0];
        end
    end

    // read data: inputs and slot number, outputs and strobes read zero
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = `IDP_ZERO_WORD;
        case (sel)
            IDP_REG_PORT0: begin
                if (HAS_IN) begin
                    rdata_d = in_lvl[31:0];
                end
            end
            IDP_REG_PORT1: begin
                if (HAS_IN) begin
                    rdata_d = in_lvl[63:32];
                end
            end
            IDP_REG_LED: begin
                rdata_d[SLOT_W-1:0] = slot_lvl;
            end
            default: begin
                rdata_d = `IDP_ZERO_WORD;
            end
        endcase
    end

    // answer one cycle after each request inside the i/o window; target only, no initiation
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            lb_rsp_o <= '0;
        end else begin
            lb_rsp_o.ack <= lb_valid_i && hit;
            lb_rsp_o.rdata <= rd_act ? rdata_d : `IDP_ZERO_WORD;
        end
    end

endmodule // idp_port

// File: tb/idp_port_sva.sv
// checker of the isolated dio port: bus answers, outputs, interrupts, header
// assumes combined variant, bound to every idp_port instance
`timescale 1ns/100ps
module idp_port_sva
    import idp_pkg::*;
(
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         reset_n_i,
    // watched ports
    input  wire logic         lb_valid_i,
    input  wire idp_req_t     lb_req_i,
    input  wire idp_rsp_t     lb_rsp_o,
    input  wire logic         cfg_valid_i,
    input  wire idp_cfg_req_t cfg_req_i,
    input  wire logic [31:0]  cfg_rdata_o,
    input  wire logic [63:0]  iso_out_o,
    input  wire logic [1:0]   int_en_i,
    input  wire logic [1:0]   int_pend_o,
    input  wire logic         irq_o
);
    logic [31:0] bar_q;
    logic        hit;
    logic        wr_ok;
    // shadow of the i/o base
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i)
            bar_q <= 32'h0000_0000;
        else if (cfg_valid_i && cfg_req_i.wr && cfg_req_i.addr == 8'h18)
            bar_q <= cfg_req_i.wdata;
    end
    assign hit = lb_valid_i && lb_req_i.addr[31:7] == bar_q[31:7];
    assign wr_ok = hit && lb_req_i.wr && lb_req_i.be == 4'hF;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    a_ack_has_req: assert property (lb_rsp_o.ack |-> $past(hit))
        else $error("ack without request");
    a_req_gets_ack: assert property (hit |=> lb_rsp_o.ack)
        else $error("request not answered");
    a_idle_rdata: assert property (!lb_rsp_o.ack |-> lb_rsp_o.rdata == 32'h0000_0000)
        else $error("read data outside answer");
    a_out_write: assert property (wr_ok && lb_req_i.addr[6:0] == 7'h00
        |=> iso_out_o == {32'h0000_0000, $past(lb_req_i.wdata)}) else $error("output word wrong");
    a_out_hold: assert property (!wr_ok |=> $stable(iso_out_o))
        else $error("outputs moved without write");
    a_irq_is_or: assert property (irq_o == |int_pend_o)
        else $error("irq not or of pending");
    a_clear_all: assert property (wr_ok && lb_req_i.addr[6:0] == 7'h40 && int_en_i == 2'b00
        |=> int_pend_o == 2'b00) else $error("clear write left pending");
    a_pend_enabled: assert property ((int_pend_o & ~$past(int_pend_o) & ~$past(int_en_i)) == 2'b00)
        else $error("pending set while disabled");
    a_bar_read: assert property (cfg_valid_i && !cfg_req_i.wr && cfg_req_i.addr == 8'h18
        |=> cfg_rdata_o == {bar_q[31:1], 1'b1}) else $error("io base read wrong");
endmodule // idp_port_sva

bind idp_port idp_port_sva idp_port_sva_inst (.clk_sys_i, .reset_n_i, .lb_valid_i, .lb_req_i,
    .lb_rsp_o, .cfg_valid_i, .cfg_req_i, .cfg_rdata_o, .iso_out_o, .int_en_i, .int_pend_o, .irq_o);

// File: tb/idp_host.sv
// host side model: local bus accesses with any byte enables, and header accesses
// assumes one access at a time, answer one edge after the taking edge
`timescale 1ns/100ps
module idp_host
    import idp_pkg::*;
(
    // clock
    input  wire logic    clk_sys_i,
    // local bus master
    input  wire idp_rsp_t lb_rsp_i,
    output idp_req_t     lb_req_o,
    output logic         lb_valid_o,
    // header port master
    output idp_cfg_req_t cfg_req_o,
    output logic         cfg_valid_o
);
    initial begin
        lb_valid_o = 1'b0;
        lb_req_o = '0;
        cfg_valid_o = 1'b0;
        cfg_req_o = '0;
    end
    // target only answers; host starts every access
    task automatic bus(input logic w, input logic [3:0] b, input logic [31:0] a, d,
                       output logic [31:0] r, output logic ok);
        @(posedge clk_sys_i);
        lb_valid_o <= 1'b1;
        lb_req_o <= '{w, b, a, d};
        @(posedge clk_sys_i);
        lb_valid_o <= 1'b0;
        lb_req_o <= ~lb_req_o;
        @(posedge clk_sys_i);
        ok = lb_rsp_i.ack;
        r = lb_rsp_i.rdata;
    endtask
    task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        cfg_valid_o <= 1'b1;
        cfg_req_o <= '{w, a, d};
        @(posedge clk_sys_i);
        cfg_valid_o <= 1'b0;
        @(posedge clk_sys_i);
    endtask
endmodule // idp_host

// File: tb/tb_top.sv
// self-checking bench of the combined, input-only and output-only isolated dio port variants
// assumes idp_host drives the bus, checker bound by its own file
`timescale 1ns/100ps
module tb_top;
    import idp_pkg::*;
    typedef struct packed {
        logic w; logic [3:0] b; logic [7:0] a; logic [31:0] d; logic [31:0] e;
    } idp_row_t;
    logic         clk_sys_i, reset_n_i, lb_valid_i, cfg_valid_i, irq_o, ok;
    idp_req_t     lb_req_i;
    idp_rsp_t     lb_rsp_o;
    idp_cfg_req_t cfg_req_i;
    logic [31:0]  cfg_rdata_o, rd;
    logic [63:0]  iso_in_i, iso_out_o;
    logic [1:0]   int_en_i, int_pend_o;
    logic [3:0]   led_o;
    int           error_cnt, compares, cyc;
    logic         b_valid, b_cfg_valid, in_irq;
    idp_req_t     b_req;
    idp_rsp_t     in_rsp, out_rsp;
    idp_cfg_req_t b_cfg_req;
    logic [63:0]  out_iso_out;
    logic [1:0]   in_pend;
    logic [3:0]   in_led;
    idp_row_t rows [6] = '{
        '{1'b1, 4'hF, 8'h00, 32'h5555_AAAA, 32'h5555_AAAA},
        '{1'b1, 4'h3, 8'h00, 32'hFFFF_FFFF, 32'h5555_AAAA},
        '{1'b1, 4'hF, 8'h04, 32'h1234_5678, 32'h5555_AAAA},
        '{1'b0, 4'hF, 8'h00, 32'h0000_0000, 32'hA5C3_0F0C},
        '{1'b0, 4'hF, 8'h40, 32'h0000_0000, 32'h0000_0000},
        '{1'b0, 4'hF, 8'h50, 32'h0000_0000, 32'h0000_0000}};
    idp_port #(.VARIANT(IDP_VAR_COMBINED)) idp_port_inst (.clk_sys_i, .reset_n_i, .lb_valid_i,
        .lb_req_i, .lb_rsp_o, .cfg_valid_i, .cfg_req_i, .cfg_rdata_o, .iso_in_i, .iso_out_o,
        .int_en_i, .int_pend_o, .irq_o, .slot_i(5'h03), .led_o);
    idp_host idp_host_inst (.clk_sys_i, .lb_rsp_i(lb_rsp_o), .lb_req_o(lb_req_i),
        .lb_valid_o(lb_valid_i), .cfg_req_o(cfg_req_i), .cfg_valid_o(cfg_valid_i));
    idp_port #(.VARIANT(IDP_VAR_IN_ONLY), .REAR_IO(1'b1)) idp_port_in_inst (.clk_sys_i,
        .reset_n_i, .lb_valid_i(b_valid), .lb_req_i(b_req), .lb_rsp_o(in_rsp),
        .cfg_valid_i(b_cfg_valid), .cfg_req_i(b_cfg_req), .cfg_rdata_o(), .iso_in_i,
        .iso_out_o(), .int_en_i, .int_pend_o(in_pend), .irq_o(in_irq), .slot_i(5'h13),
        .led_o(in_led));
    idp_port #(.VARIANT(IDP_VAR_OUT_ONLY)) idp_port_out_inst (.clk_sys_i, .reset_n_i,
        .lb_valid_i(b_valid), .lb_req_i(b_req), .lb_rsp_o(out_rsp), .cfg_valid_i(1'b0),
        .cfg_req_i('0), .cfg_rdata_o(), .iso_in_i, .iso_out_o(out_iso_out), .int_en_i,
        .int_pend_o(), .irq_o(), .slot_i(5'h03), .led_o());
    idp_host idp_host_wide_inst (.clk_sys_i, .lb_rsp_i(in_rsp | out_rsp), .lb_req_o(b_req),
        .lb_valid_o(b_valid), .cfg_req_o(b_cfg_req), .cfg_valid_o(b_cfg_valid));
    task automatic chk(input logic [63:0] got, exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 1000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        reset_n_i = 1'b0;
        iso_in_i = 64'h3C69_96E1_A5C3_0F0C;
        int_en_i = 2'b01;
        repeat (4) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        foreach (rows[i]) begin
            idp_host_inst.bus(rows[i].w, rows[i].b, {24'h00_0000, rows[i].a}, rows[i].d, rd, ok);
            chk({63'h0, ok}, 64'h1);
            chk(rows[i].w ? iso_out_o : {32'h0, rd}, {32'h0, rows[i].e});
        end
        chk({60'h0, led_o}, 64'h0);
        $display("table done");
        @(posedge clk_sys_i) iso_in_i <= iso_in_i | 64'h3;
        repeat (8) @(posedge clk_sys_i);
        chk({61'h0, irq_o, int_pend_o}, 64'h5);
        @(posedge clk_sys_i) int_en_i <= 2'b00;
        idp_host_inst.bus(1'b1, 4'hF, 32'h0000_0040, 32'hFFFF_FFFF, rd, ok);
        chk({62'h0, int_pend_o}, 64'h0);
        $display("interrupt done");
        idp_host_wide_inst.cfg(1'b1, 8'h18, 32'h0000_0080);
        idp_host_wide_inst.bus(1'b0, 4'hF, 32'h0000_0080, 32'h0000_0000, rd, ok);
        chk({31'h0, ok, rd}, 64'h1_A5C3_0F0F);
        idp_host_wide_inst.bus(1'b0, 4'hF, 32'h0000_0084, 32'h0000_0000, rd, ok);
        chk({31'h0, ok, rd}, 64'h1_3C69_96E1);
        chk({61'h0, in_irq, in_pend}, 64'h5);
        idp_host_wide_inst.bus(1'b1, 4'hF, 32'h0000_0088, 32'hFFFF_FFFF, rd, ok);
        chk({62'h0, in_pend}, 64'h0);
        idp_host_wide_inst.bus(1'b1, 4'hF, 32'h0000_00D0, 32'hFFFF_FFF5, rd, ok);
        chk({60'h0, in_led}, 64'h5);
        idp_host_wide_inst.bus(1'b0, 4'hF, 32'h0000_00D0, 32'h0000_0000, rd, ok);
        chk({31'h0, ok, rd}, 64'h1_0000_0013);
        idp_host_wide_inst.bus(1'b1, 4'hF, 32'h0000_0000, 32'hC0DE_0001, rd, ok);
        idp_host_wide_inst.bus(1'b1, 4'hF, 32'h0000_0004, 32'h8421_0F00, rd, ok);
        chk(out_iso_out, 64'h8421_0F00_C0DE_0001);
        idp_host_wide_inst.bus(1'b0, 4'hF, 32'h0000_0004, 32'h0000_0000, rd, ok);
        chk({31'h0, ok, rd}, 64'h1_0000_0000);
        $display("variants done");
        idp_host_inst.cfg(1'b1, 8'h14, 32'h1234_5670);
        idp_host_inst.cfg(1'b0, 8'h14, 32'h0000_0000);
        chk({32'h0, cfg_rdata_o}, 64'h1234_5671);
        idp_host_inst.cfg(1'b1, 8'h18, 32'h0000_0080);
        idp_host_inst.cfg(1'b0, 8'h18, 32'h0000_0000);
        chk({32'h0, cfg_rdata_o}, 64'h81);
        idp_host_inst.bus(1'b1, 4'hF, 32'h0000_0080, 32'h0F0F_0F0F, rd, ok);
        chk(iso_out_o, 64'h0F0F_0F0F);
        idp_host_inst.bus(1'b1, 4'hF, 32'h0000_0000, 32'hFFFF_FFFF, rd, ok);
        chk({63'h0, ok}, 64'h0);
        $display("header done");
        @(posedge clk_sys_i) reset_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        chk(iso_out_o, 64'h0);
        $display("reset done");
        final_report();
    end
endmodule // tb_top
